//--- verilog/arsc_top.sv
// reset sources, start-up sequencing, sample marking and register map checksum
// assumes: classic wishbone master on ref_clk_i; serial front end delivers word strobes on ref_clk_i;
// sync/reset pin and external modulator clock are asynchronous pins
// limitation: only the control side of the converter lives here; sample marking
// stands in for the filter outputs, which carry no data in this block
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "arsc_cfg.svh"
module arsc_top #(
  parameter int POR_CYCLES    = 64,   // power-on interval in clock cycles
  parameter int ACQ_CYCLES    = 32,   // register_acquire_time in clock cycles
  parameter int RST_PULSE_CYC = 16,   // reset_pulse_threshold in clock cycles
  parameter int OSC_DIV       = 8,    // internal oscillator as clock divider
  parameter int OVERSAMPLING_RATIO           = `ARSC_OSR_DEFAULT  // oversampling_ratio
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,           // power-on reset
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sync_reset_n_i,    // dual-function pin
  input  wire logic        external_clock_input_i,
  input  wire logic        frame_cs_n_i,      // serial frame select, same clock
  input  wire logic        frame_word_i,      // one word completed
  input  wire logic        frame_word_reset_i,// completed word is reset command
  input  wire logic        null_status_sent_i,// status returned for null command
  output logic             data_ready_pin_o,
  output logic             sample_fast_o      // current sample from fast path
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  pin_sync;       // reset pin two-stage
  logic [2:0]  eclk_sync;      // external clock two-stage plus edge stage
  // both pins cross from outside; the reset pin feeds logic from its second stage only, the external clock from its second and third
  always_ff @(posedge ref_clk_i) begin
    pin_sync  <= {pin_sync[0], sync_reset_n_i};
    eclk_sync <= {eclk_sync[1:0], external_clock_input_i};
  end
  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic [$clog2(RST_PULSE_CYC+1)-1:0] low_cnt;  // pin low duration
  logic        pin_rst;        // pin reset held
  logic        cmd_rst;        // command reset pulse
  logic        soft_rst;       // pin or command reset
  logic        ready;          // serial port ready
  logic [1:0]  word_cnt;       // words in current frame
  logic        frame_has_rst;  // first word was reset
  // a pin reset stays asserted for as long as the pin is held low
  assign soft_rst = pin_rst | cmd_rst;
  // long low detection; held until pin returns high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || pin_sync[1]) begin
      low_cnt <= '0;
      pin_rst <= 1'b0;
    end else if (low_cnt == RST_PULSE_CYC[$bits(low_cnt)-1:0]) begin
      pin_rst <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 1'b1;
    end
  end
  // frame word counting, traffic before ready ignored
  // cs_n high or a reset drops a half-sent frame, so a cut reset word is lost
  always_ff @(posedge ref_clk_i) begin
    cmd_rst <= 1'b0;
    if (!rst_n_i || soft_rst || frame_cs_n_i || !ready) begin
      word_cnt      <= '0;
      frame_has_rst <= 1'b0;
    end else if (frame_word_i) begin
      word_cnt <= word_cnt + 2'd1;
      if (word_cnt == 2'd0) begin
        frame_has_rst <= frame_word_reset_i;
      end
      if (word_cnt == 2'(`ARSC_FRAME_WORDS - 1)) begin
        cmd_rst <= frame_has_rst;
      end
    end
  end
  // ----------------------------------------------------------------
  // wishbone slave and registers
  // ----------------------------------------------------------------
  arsc_pkg::arsc_wb_req_t req;
  logic        chk_en;         // checksum enable
  logic        chk_type;       // 0 ccitt, 1 crc-16
  logic        osc_sel;        // internal oscillator
  logic [15:0] map_mem [`ARSC_MAP_WORDS];  // covered map 02h..12h
  logic [15:0] checksum;       // last completed checksum
  logic        map_chg;        // map-changed flag
  logic        sinc3_on;       // sinc3 path selected
  logic [15:0] sample_cnt;     // samples since start-up
  logic        wb_go;          // request taken this cycle
  logic        map_hit;        // address falls in covered map
  logic [4:0]  map_idx;        // map word index
  logic        stat_rd;        // status read taken
  assign req     = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
  assign wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // map words sit four bytes apart; truncation folds the base offset away
  assign map_idx = 5'(req.adr[7:2] - 6'(`ARSC_MAP_FIRST));
  // window 0x88..0xc8; anything else is a plain register or unmapped
  assign map_hit = req.adr >= 8'(`ARSC_OFS_MAP_BASE + {`ARSC_MAP_FIRST, 2'b00}) &&
                   req.adr <= 8'(`ARSC_OFS_MAP_BASE + {`ARSC_MAP_LAST, 2'b00});
  assign stat_rd = wb_go & ~req.we & (req.adr == `ARSC_OFS_STATUS);
  // ack one cycle after request, dropped next cycle
  // a new request is only taken once ack has dropped again
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_go;
    end
  end
  // control bits; any reset returns defaults
  // oscillator select falls back to the external clock on every reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      chk_en   <= 1'b0;
      chk_type <= 1'b0;
      osc_sel  <= 1'b0;
    end else if (wb_go && req.we && req.adr == `ARSC_OFS_CTRL && req.sel[0]) begin
      chk_en   <= req.dat[`ARSC_CTRL_CHK_EN];
      chk_type <= req.dat[`ARSC_CTRL_CHK_TYPE];
      osc_sel  <= req.dat[`ARSC_CTRL_OSC_SEL];
    end
  end
  // covered map words, byte lanes honoured
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      for (int i = 0; i < `ARSC_MAP_WORDS; i++) begin
        map_mem[i] <= 16'h0000;
      end
    end else if (wb_go && req.we && map_hit) begin
      if (req.sel[0]) begin
        map_mem[map_idx][7:0] <= req.dat[7:0];
      end
      if (req.sel[1]) begin
        map_mem[map_idx][15:8] <= req.dat[15:8];
      end
    end
  end
  // read data, captured with the ack
  // a status read returns the flag before its clear lands
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_go && !req.we) begin
      if (map_hit) begin
        wb_dat_o <= {16'h0000, map_mem[map_idx]};
      end else begin
        unique case (req.adr)
          `ARSC_OFS_CTRL:     wb_dat_o <= {29'h0, osc_sel, chk_type, chk_en};
          `ARSC_OFS_STATUS:   wb_dat_o <= {29'h0, sinc3_on, ready, map_chg};
          `ARSC_OFS_CHECKSUM: wb_dat_o <= {16'h0000, checksum};
          `ARSC_OFS_SAMPLES:  wb_dat_o <= {16'h0000, sample_cnt};
          default:            wb_dat_o <= 32'h0000_0000;  // unmapped
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // modulator clock tick
  // ----------------------------------------------------------------
  logic [$clog2(OSC_DIV)-1:0] osc_cnt;  // internal oscillator divider
  logic        mod_tick;       // one modulator period
  // internal oscillator is a plain divider; it stands still while deselected
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst || !osc_sel) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= (osc_cnt == $bits(osc_cnt)'(OSC_DIV - 1)) ? '0 : osc_cnt + 1'b1;
    end
  end
  assign mod_tick = osc_sel ? (osc_cnt == $bits(osc_cnt)'(OSC_DIV - 1))
                            : (eclk_sync[1] & ~eclk_sync[2]);
  // ----------------------------------------------------------------
  // map checksum engine
  // ----------------------------------------------------------------
  logic [8:0]  bit_cnt;        // bit position in walk
  logic [15:0] crc;            // running value
  logic        have_prev;      // a previous pass exists
  logic        walk_bit;       // current map bit
  logic [15:0] poly;           // selected polynomial
  logic        pass_done;      // last bit folded this cycle
  logic [15:0] next_crc;       // value after folding
  // word index from the upper bits, msb of each word taken first
  assign walk_bit  = map_mem[bit_cnt[8:4]][4'hf - bit_cnt[3:0]];
  assign poly      = chk_type ? `ARSC_POLY_ANSI : `ARSC_POLY_CCITT;
  assign next_crc  = {crc[14:0], 1'b0} ^ ((crc[15] ^ walk_bit) ? poly : 16'h0000);
  assign pass_done = chk_en & mod_tick & (bit_cnt == `ARSC_MAP_BITS - 9'd1);
  // bit walk, one bit per modulator tick
  // dropping the enable restarts the walk from the seed
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst || !chk_en) begin
      bit_cnt <= 9'd0;
      crc     <= `ARSC_SEED;
    end else if (mod_tick) begin
      if (pass_done) begin
        bit_cnt <= 9'd0;
        crc     <= `ARSC_SEED;
      end else begin
        bit_cnt <= bit_cnt + 9'd1;
        crc     <= next_crc;
      end
    end
  end
  // stored result and comparison with previous pass
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      checksum  <= 16'h0000;
      have_prev <= 1'b0;
    end else if (pass_done) begin
      checksum  <= next_crc;
      have_prev <= 1'b1;
    end
  end
  // flag: set wins over clear
  // a clear in the cycle of a differing pass must not hide the change
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      map_chg <= 1'b0;
    end else if (pass_done && have_prev && next_crc != checksum) begin
      map_chg <= 1'b1;
    end else if (stat_rd || (null_status_sent_i && ready)) begin
      map_chg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // start-up sequence and sample marking
  // ----------------------------------------------------------------
  arsc_pkg::arsc_state_t state;
  logic [15:0] seq_cnt;        // cycles or modulator periods
  logic        por_done;       // power-on interval already spent
  logic [2:0]  data_ready_pin_low;       // low pulse remaining
  logic        sample_evt;     // new sample this cycle
  assign sample_evt = (state == arsc_pkg::ARSC_ST_CONV) && mod_tick &&
                      seq_cnt == 16'(OVERSAMPLING_RATIO - 1);
  // power-on interval only once; later resets use the acquire time
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state    <= arsc_pkg::ARSC_ST_RESET;
      seq_cnt  <= 16'h0000;
      por_done <= 1'b0;
    end else if (soft_rst) begin
      state    <= arsc_pkg::ARSC_ST_RESET;
      seq_cnt  <= 16'h0000;
    end else begin
      unique case (state)
        arsc_pkg::ARSC_ST_RESET: begin
          state   <= arsc_pkg::ARSC_ST_ACQ;
          seq_cnt <= 16'h0000;
        end
        arsc_pkg::ARSC_ST_ACQ: begin
          // power-on interval once, acquire time after pin or command
          if (seq_cnt == 16'(por_done ? ACQ_CYCLES - 1 : POR_CYCLES - 1)) begin
            state    <= arsc_pkg::ARSC_ST_WAIT;
            seq_cnt  <= 16'h0000;
            por_done <= 1'b1;
          end else begin
            seq_cnt <= seq_cnt + 16'h0001;
          end
        end
        arsc_pkg::ARSC_ST_WAIT: begin
          if (mod_tick) begin
            if (seq_cnt == 16'(`ARSC_MOD_WAIT - 1)) begin
              state   <= arsc_pkg::ARSC_ST_CONV;
              seq_cnt <= 16'h0000;
            end else begin
              seq_cnt <= seq_cnt + 16'h0001;
            end
          end
        end
        arsc_pkg::ARSC_ST_CONV: begin
          if (mod_tick) begin
            seq_cnt <= sample_evt ? 16'h0000 : seq_cnt + 16'h0001;
          end
        end
      endcase
    end
  end
  assign ready = (state == arsc_pkg::ARSC_ST_WAIT) || (state == arsc_pkg::ARSC_ST_CONV);
  // sample counting and filter selection
  // count saturates so a long run never wraps back into fast mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      sample_cnt    <= 16'h0000;
      sinc3_on      <= 1'b0;
      sample_fast_o <= 1'b1;
    end else if (sample_evt) begin
      if (sample_cnt != 16'hffff) begin
        sample_cnt <= sample_cnt + 16'h0001;
      end
      sample_fast_o <= (sample_cnt < 16'(`ARSC_FAST_SAMPLES));
      sinc3_on      <= (sample_cnt >= 16'(`ARSC_FAST_SAMPLES));
    end
  end
  // data-ready pin: low in reset, high when ready, low pulse per sample
  // registered so the host never sees a glitch on the pin
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      data_ready_pin_low         <= 3'd0;
      data_ready_pin_o <= 1'b0;
    end else if (sample_evt) begin
      data_ready_pin_low         <= 3'(`ARSC_DATA_READY_PIN_LOW_CYC - 1);
      data_ready_pin_o <= 1'b0;
    end else if (data_ready_pin_low != 3'd0) begin
      data_ready_pin_low <= data_ready_pin_low - 3'd1;
    end else begin
      data_ready_pin_o <= ready;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // every property below watches state that the block drives itself, except early_drop_a (frame_cs_n_i) and flag_clear_a and read_value_a (wishbone inputs)
  seed_start_a: assert property (pass_done && !soft_rst |=> crc == `ARSC_SEED && bit_cnt == 9'd0)
    else $error("walk did not restart from seed");
  store_sum_a: assert property (pass_done && !soft_rst |=> checksum == $past(next_crc))
    else $error("checksum not stored after pass");
  step_bit_a: assert property (chk_en && !mod_tick && !soft_rst |=> $stable(bit_cnt))
    else $error("walk advanced without modulator tick");
  flag_set_a: assert property (pass_done && have_prev && next_crc != checksum && !soft_rst |=> map_chg)
    else $error("map change not flagged");
  flag_clear_a: assert property (stat_rd && !(pass_done && have_prev) && !soft_rst |=> !map_chg)
    else $error("status read left flag set");
  read_value_a: assert property (stat_rd && map_chg |=> wb_dat_o[`ARSC_STAT_MAP_CHG])
    else $error("clearing read lost flag value");
  hold_rst_a: assert property (pin_rst |=> state == arsc_pkg::ARSC_ST_RESET || state == arsc_pkg::ARSC_ST_ACQ)
    else $error("pin reset not held");
  early_drop_a: assert property (frame_cs_n_i |=> !cmd_rst)
    else $error("reset from ended frame");
  pin_low_a: assert property (state == arsc_pkg::ARSC_ST_RESET |=> !data_ready_pin_o)
    else $error("ready pin high in reset");
  wait_len_a: assert property (state == arsc_pkg::ARSC_ST_WAIT && mod_tick && !soft_rst
                                 && seq_cnt < 16'(`ARSC_MOD_WAIT - 1) |=> state == arsc_pkg::ARSC_ST_WAIT)
    else $error("initial wait cut short");
  fast_pair_a: assert property (sample_evt && !soft_rst && sample_cnt < 16'(`ARSC_FAST_SAMPLES) |=> sample_fast_o)
    else $error("early sample not from fast path");
  osc_back_a: assert property (soft_rst |=> !osc_sel)
    else $error("oscillator select kept over reset");
  // main scenarios: command reset, pin reset, map change, sinc3 handover
  cmd_rst_c: cover property (cmd_rst);
  pin_rst_c: cover property (pin_rst ##1 !pin_rst);
  map_chg_c: cover property (pass_done && have_prev && next_crc != checksum);
  sinc3_c:   cover property ($rose(sinc3_on));
endmodule : arsc_top

//--- shared/arsc_cfg.svh
// offsets, field positions, reset values and timing counts of the reset/start-up/map checksum block
// assumes: included by bare name from the package and the design file
`ifndef ARSC_CFG_SVH
`define ARSC_CFG_SVH
// ----------------------------------------------------------------
// wishbone register offsets (byte addresses)
// ----------------------------------------------------------------
`define ARSC_OFS_CTRL      8'h00
`define ARSC_OFS_STATUS    8'h04
`define ARSC_OFS_CHECKSUM  8'h08
`define ARSC_OFS_SAMPLES   8'h0c
`define ARSC_OFS_MAP_BASE  8'h80
// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define ARSC_CTRL_CHK_EN   0
`define ARSC_CTRL_CHK_TYPE 1
`define ARSC_CTRL_OSC_SEL  2
`define ARSC_STAT_MAP_CHG  0
`define ARSC_STAT_READY    1
`define ARSC_STAT_SINC3    2
// ----------------------------------------------------------------
// covered map and checksum constants
// ----------------------------------------------------------------
`define ARSC_MAP_FIRST     8'h02
`define ARSC_MAP_LAST      8'h12
`define ARSC_MAP_WORDS     17
`define ARSC_MAP_BITS      9'd272
`define ARSC_SEED          16'hffff
`define ARSC_POLY_CCITT    16'h1021
`define ARSC_POLY_ANSI     16'h8005
// ----------------------------------------------------------------
// timing counts, in modulator periods, clock cycles, samples or frame words
// ----------------------------------------------------------------
`define ARSC_MOD_WAIT_BASE 256
`define ARSC_MOD_WAIT_EXT  44
`define ARSC_MOD_WAIT      (`ARSC_MOD_WAIT_BASE + `ARSC_MOD_WAIT_EXT)
`define ARSC_FAST_SAMPLES  2
`define ARSC_OSR_DEFAULT   1024
`define ARSC_FRAME_WORDS   4
`define ARSC_DATA_READY_PIN_LOW_CYC  4
`endif

//--- shared/arsc_pkg.sv
// types of the reset/start-up/map checksum block
// assumes: constants come from arsc_cfg.svh
`include "arsc_cfg.svh"
package arsc_pkg;
  // ----------------------------------------------------------------
  // start-up sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ARSC_ST_RESET = 2'b00,  // held in reset
    ARSC_ST_ACQ   = 2'b01,  // internal settle, port not ready
    ARSC_ST_WAIT  = 2'b10,  // modulator initial wait
    ARSC_ST_CONV  = 2'b11   // producing samples
  } arsc_state_t;
  // wishbone request carried as one word
  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } arsc_wb_req_t;
endpackage : arsc_pkg

//--- dv/arsc_host_model.sv
// host model: serial frame words, sync/reset pin and null-command responses
// assumes: shares the block's clock; the bench calls its tasks by hierarchical name
`timescale 1ns/10ps
module arsc_host_model (
  input  wire logic clk_i,
  input  wire logic data_ready_pin_i,
  output logic      frame_cs_n_o,
  output logic      frame_word_o,
  output logic      frame_word_reset_o,
  output logic      null_status_sent_o,
  output logic      sync_reset_n_o
);
  initial begin
    frame_cs_n_o = 1'b1;
    frame_word_o = 1'b0;
    frame_word_reset_o = 1'b0;
    null_status_sent_o = 1'b0;
    sync_reset_n_o = 1'b1;
  end
  // one frame of n words, reset command in word one; n below four ends it early
  // ok falls when the ready pin never rose within the bound
  task automatic frame(input logic rst, input int n, output logic ok);
    int i;
    for (i = 0; i < 300 && data_ready_pin_i !== 1'b1; i++) @(posedge clk_i);
    ok = (i < 300);
    @(posedge clk_i);
    frame_cs_n_o <= 1'b0;
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      frame_word_o <= 1'b1;
      frame_word_reset_o <= rst && i == 0;
      @(posedge clk_i);
      frame_word_o <= 1'b0;
      frame_word_reset_o <= 1'b0;
    end
    @(posedge clk_i);
    frame_cs_n_o <= 1'b1;
  endtask : frame
  // dual-function pin level
  task automatic pin(input logic v);
    @(posedge clk_i);
    sync_reset_n_o <= v;
  endtask : pin
  // status word sent as reply to a null command
  task automatic null_resp();
    @(posedge clk_i);
    null_status_sent_o <= 1'b1;
    @(posedge clk_i);
    null_status_sent_o <= 1'b0;
  endtask : null_resp
endmodule : arsc_host_model

//--- dv/arsc_top_tb.sv
// self-checking bench of arsc_top
// assumes: arsc_pkg and arsc_host_model compiled first; shortened oversampling_ratio
`timescale 1ns/10ps
`include "arsc_cfg.svh"
module arsc_top_tb;
  localparam int OVERSAMPLING_RATIO = 8;             // shortened oversampling_ratio
  logic                   ref_clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic                   mclk = 1'b0;  // modulator clock pin
  logic                   cs = 1'b0;    // wishbone cyc and stb
  arsc_pkg::arsc_wb_req_t req = '0;
  logic [31:0]            wb_dat_o, q;
  logic                   wb_ack_o, data_ready_pin_o, sample_fast_o, cs_n, wd, wr, nul, sync_n;
  logic [15:0]            map [17];     // expected covered map
  int                     bad_count = 0, n_checks = 0, cyc = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  initial begin
    #3;
    forever #32 mclk = ~mclk;
  end
  arsc_top #(.OVERSAMPLING_RATIO(OVERSAMPLING_RATIO)) i_arsc_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cs), .wb_stb_i(cs),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sync_reset_n_i(sync_n), .external_clock_input_i(mclk), .frame_cs_n_i(cs_n),
    .frame_word_i(wd), .frame_word_reset_i(wr), .null_status_sent_i(nul),
    .data_ready_pin_o(data_ready_pin_o), .sample_fast_o(sample_fast_o));
  arsc_host_model i_arsc_host_model (.clk_i(ref_clk_i), .data_ready_pin_i(data_ready_pin_o),
    .frame_cs_n_o(cs_n), .frame_word_o(wd), .frame_word_reset_o(wr), .null_status_sent_o(nul),
    .sync_reset_n_o(sync_n));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // classic single cycle, read data lands in q
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    cs <= 1'b1;
    req <= '{adr: a, we: we, sel: 4'hf, dat: d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge ref_clk_i);
    q = wb_dat_o;
    cs <= 1'b0;
    if (i == 20) begin
      chk(0, 1, "ack timeout");
      stop_test();
    end
  endtask : wb
  // frame with reset in word one; a ready pin that never rises ends the run
  task automatic frame(input int n);
    logic ok;
    i_arsc_host_model.frame(1'b1, n, ok);
    if (!ok) begin
      chk(0, 1, "ready timeout before frame");
      stop_test();
    end
  endtask : frame
  task automatic wait_rdy(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && data_ready_pin_o !== v; i++) @(posedge ref_clk_i);
    if (i == lim) begin
      chk(0, 1, "data ready timeout");
      stop_test();
    end
  endtask : wait_rdy
  function automatic logic [15:0] crc(input logic ty);
    logic [15:0] c;
    logic        fb;
    c = `ARSC_SEED;
    for (int w = 0; w < 17; w++)
      for (int b = 15; b >= 0; b--) begin
        fb = c[15] ^ map[w][b];
        c = {c[14:0], 1'b0} ^ (fb ? (ty ? `ARSC_POLY_ANSI : `ARSC_POLY_CCITT) : 16'h0000);
      end
    return c;
  endfunction : crc
  // poll checksum register until a pass of the expected map lands
  task automatic poll(input logic ty);
    for (int i = 0; i < 60; i++) begin
      repeat (100) @(posedge ref_clk_i);
      wb(1'b0, `ARSC_OFS_CHECKSUM, '0);
      if (q[15:0] === crc(ty)) break;
    end
    chk(q, {16'h0000, crc(ty)}, "map checksum");
  endtask : poll
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_por();
    int t0;
    t0 = cyc;
    wait_rdy(1'b1, 200);
    chk(32'(cyc - t0 >= 64), 1, "power-on interval");
    wb(1'b0, `ARSC_OFS_CTRL, '0);
    chk(q, 0, "ctrl default");
    wb(1'b0, 8'h40, '0);
    chk(q, 0, "unmapped read");
    wb(1'b0, `ARSC_OFS_STATUS, '0);
    chk(q & 32'h6, 32'h2, "status after power-on");
    $display("test por done");
  endtask : t_por
  task automatic t_crc();
    for (int w = 0; w < 17; w++) begin
      map[w] = 16'(w * 16'h0913 + 16'h00a5);
      wb(1'b1, 8'(`ARSC_OFS_MAP_BASE + 4 * (w + 2)), {16'h0000, map[w]});
    end
    wb(1'b1, `ARSC_OFS_CTRL, 32'h1);
    poll(1'b0);
    wb(1'b0, `ARSC_OFS_STATUS, '0);
    chk(q[0], 0, "no change flagged");
    map[16] ^= 16'h0001;
    wb(1'b1, 8'hc8, {16'h0000, map[16]});
    poll(1'b0);
    wb(1'b0, `ARSC_OFS_STATUS, '0);
    chk(q[0], 1, "change flagged");
    wb(1'b0, `ARSC_OFS_STATUS, '0);
    chk(q[0], 0, "flag cleared by read");
    wb(1'b1, `ARSC_OFS_CTRL, 32'h3);
    map[0] ^= 16'h8000;
    wb(1'b1, 8'h88, {16'h0000, map[0]});
    poll(1'b1);
    i_arsc_host_model.null_resp();
    wb(1'b0, `ARSC_OFS_STATUS, '0);
    chk(q[0], 0, "flag cleared by null reply");
    $display("test checksum done");
  endtask : t_crc
  task automatic t_cmd_rst();
    int t0;
    wb(1'b1, `ARSC_OFS_CTRL, 32'h5);
    frame(3);
    wb(1'b0, `ARSC_OFS_CTRL, '0);
    chk(q, 32'h5, "early-ended frame");
    frame(4);
    wait_rdy(1'b0, 6);
    t0 = cyc;
    wb(1'b0, `ARSC_OFS_CTRL, '0);
    chk(q, 0, "ctrl after command reset");
    wb(1'b0, 8'h88, '0);
    chk(q, 0, "map after command reset");
    wait_rdy(1'b1, 60);
    chk(32'(cyc - t0 >= 28), 1, "acquire time");
    $display("test command reset done");
  endtask : t_cmd_rst
  task automatic t_pin_rst();
    int tf [3];
    int t0;
    wb(1'b1, `ARSC_OFS_CTRL, 32'h4);
    i_arsc_host_model.pin(1'b0);
    repeat (8) @(posedge ref_clk_i);
    i_arsc_host_model.pin(1'b1);
    wb(1'b0, `ARSC_OFS_CTRL, '0);
    chk(q, 32'h4, "short pulse no reset");
    i_arsc_host_model.pin(1'b0);
    repeat (40) @(posedge ref_clk_i);
    chk(data_ready_pin_o, 0, "held in reset");
    wb(1'b0, `ARSC_OFS_CTRL, '0);
    chk(q, 0, "oscillator select cleared");
    i_arsc_host_model.pin(1'b1);
    wait_rdy(1'b1, 60);
    t0 = cyc;
    for (int k = 0; k < 3; k++) begin
      wait_rdy(1'b0, 3000);
      tf[k] = cyc;
      repeat (2) @(posedge ref_clk_i);
      chk(sample_fast_o, 32'(k < 2), "filter path");
      wait_rdy(1'b1, 10);
    end
    chk(32'(tf[0] - t0 inside {[2456:2488]}), 1, "first sample delay");
    chk(32'(tf[2] - tf[0]), 32'(2 * OVERSAMPLING_RATIO * 8), "third sample");
    chk(32'(tf[2] - tf[1]), 32'(OVERSAMPLING_RATIO * 8), "sample spacing");
    wb(1'b0, `ARSC_OFS_STATUS, '0);
    chk(q[2], 1, "sinc3 active");
    wb(1'b0, `ARSC_OFS_SAMPLES, '0);
    chk(q, 32'h3, "sample count");
    $display("test pin reset and start-up done");
  endtask : t_pin_rst
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_por();
    t_crc();
    t_cmd_rst();
    t_pin_rst();
    stop_test();
  end
endmodule : arsc_top_tb
